// ---- bench/battery_backed_status_bank_tb.sv ----
`timescale 1ns/1ns
module battery_backed_status_bank_tb import status_bank_pkg::*;;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    reg_req_t    req = '0;
    reg_rsp_t    rsp;
    logic        wdr = 1'b0, slow = 1'b0, sup = 1'b1, batt = 1'b1, wdt = 1'b0, irq, got;
    logic [31:0] ce, alt, q;
    logic [31:0] m[8];
    int          n_fail = 0, samples_checked = 0, cyc = 0;
    always #4 i_core_clk = ~i_core_clk;
    battery_backed_status_bank dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rsp(rsp),
        .i_watchdog_reset(wdr), .i_slow_clock_detect(slow), .i_main_standby_ok(sup),
        .o_clock_enable(ce), .o_alt_standby_control(alt), .o_power_fail_irq(irq));
    task chk(input string s, input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", s, e, g);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic e);
        got = 1'b0;
        @(posedge i_core_clk);
        req <= '{1'b1, w, a, d};
        @(posedge i_core_clk);
        req.valid <= 1'b0;
        repeat (3) begin
            #1;
            if (rsp.valid === 1'b1) got = 1'b1;
            if (rsp.valid === 1'b1) q = rsp.rdata;
            @(posedge i_core_clk);
        end
        chk("resp", 32'(got), 32'(e));
    endtask
    task wr(input logic [4:0] o, input logic [31:0] d);
        acc(1'b1, BANK_BASE + 32'(o), d, sup);
        if (sup && o == OFS_PF_STATUS) batt = batt & ~d[7];
        if (sup && o == OFS_PF_STATUS) wdt = wdt & ~d[5];
        if (sup && o == OFS_CLOCK_ENABLE) m[2] = d & MASK_CLOCK_ENABLE;
        if (sup && o == OFS_ALT_STANDBY) m[6] = d & MASK_ALT_STANDBY;
    endtask
    task rd(input logic [4:0] o);
        acc(1'b0, BANK_BASE + 32'(o), 32'h0, 1'b1);
        chk("rdata", q, o == 5'h00 ? {24'h0, batt, 1'b0, wdt, 4'h0, slow} : m[o >> 2]);
        chk("irq", 32'(irq), 32'(batt | wdt));
        chk("ce", ce, m[2]);
        chk("alt", alt, m[6]);
    endtask
    task wd;
        @(posedge i_core_clk);
        wdr <= 1'b1;
        @(posedge i_core_clk);
        wdr <= 1'b0;
        wdt = 1'b1;
    endtask
    task boot;
        m = '{default: 32'h0};
        batt = 1'b1;
        wdt = 1'b0;
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
    endtask
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict;
        end
    end
    initial begin
        void'($urandom(56));
        boot;
        rd(OFS_PF_STATUS);
        wr(OFS_PF_STATUS, 32'h0000_007F);
        rd(OFS_PF_STATUS);
        wr(OFS_PF_STATUS, 32'h0000_0080);
        rd(OFS_PF_STATUS);
        wd;
        wr(OFS_PF_STATUS, 32'h0000_00DF);
        rd(OFS_PF_STATUS);
        wr(OFS_PF_STATUS, 32'h0000_0020);
        slow <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        wr(OFS_PF_STATUS, 32'h0000_0001);
        rd(OFS_PF_STATUS);
        for (int k = 1; k < 8; k++) begin
            wr(5'(k * 4), $urandom());
            rd(5'(k * 4));
        end
        acc(1'b1, BANK_BASE + 32'h28, 32'hFFFF_FFFF, 1'b0);
        acc(1'b1, 32'h0000_0408, 32'h0000_003F, 1'b0);
        rd(OFS_CLOCK_ENABLE);
        sup <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        wd;
        wr(OFS_CLOCK_ENABLE, 32'h0000_0015);
        sup <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        rd(OFS_PF_STATUS);
        rd(OFS_CLOCK_ENABLE);
        boot;
        rd(OFS_PF_STATUS);
        rd(OFS_ALT_STANDBY);
        give_verdict;
    end
endmodule

// ---- bench/status_bank_sva.sv ----
`timescale 1ns/1ns
module status_bank_sva
    import status_bank_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire reg_req_t    i_req,
    input  wire reg_rsp_t    o_rsp,
    input  wire logic        i_watchdog_reset,
    input  wire logic        i_slow_clock_detect,
    input  wire logic        i_main_standby_ok,
    input  wire logic [31:0] o_clock_enable,
    input  wire logic [31:0] o_alt_standby_control,
    input  wire logic        o_power_fail_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire rd_st = !i_req.write && i_req.addr == BANK_BASE;
    wire wr_ce = i_req.valid && i_req.write && i_req.addr == BANK_BASE + 32'h8;
    wire wr_alt = i_req.valid && i_req.write && i_req.addr == BANK_BASE + 32'h18;
    property p_win; o_rsp.valid |-> $past(i_req.valid) && $past(i_req.addr[31:5]) == BANK_BASE[31:5]; endproperty
    a_win: assert property (p_win) else $error("response outside window");
    property p_wr0; o_rsp.valid && $past(i_req.write) |-> o_rsp.rdata == 32'h0; endproperty
    a_wr0: assert property (p_wr0) else $error("write returned data");
    property p_rsv; o_rsp.valid && $past(rd_st) |-> o_rsp.rdata[31:8] == 24'h0 && !o_rsp.rdata[6] && o_rsp.rdata[4:1] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved status bits set");
    property p_irq; o_rsp.valid && $past(rd_st) |-> o_power_fail_irq == (o_rsp.rdata[7] | o_rsp.rdata[5]); endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with flags");
    property p_wdt; i_watchdog_reset |-> ##2 o_power_fail_irq; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog event missed");
    property p_ce; $changed(o_clock_enable) |-> $past(wr_ce); endproperty
    a_ce: assert property (p_ce) else $error("clock enable changed unasked");
    property p_alt; $changed(o_alt_standby_control) |-> $past(wr_alt); endproperty
    a_alt: assert property (p_alt) else $error("standby control changed unasked");
    property p_mask; o_clock_enable[31:6] == 26'h0; endproperty
    a_mask: assert property (p_mask) else $error("clock enable upper bits set");
    property p_rst; disable iff (1'b0) !i_rst_n |=> !o_rsp.valid && o_clock_enable == 32'h0 && o_alt_standby_control == 32'h0 && !o_power_fail_irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule
bind battery_backed_status_bank status_bank_sva chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .o_rsp(o_rsp), .i_watchdog_reset(i_watchdog_reset), .i_slow_clock_detect(i_slow_clock_detect),
    .i_main_standby_ok(i_main_standby_ok), .o_clock_enable(o_clock_enable),
    .o_alt_standby_control(o_alt_standby_control), .o_power_fail_irq(o_power_fail_irq));

// ---- hdl/battery_backed_status_bank.sv ----
// Behaviour
// RULE1: The battery power-on reset returns every register and all logic of the bank to its default.
// RULE2: Every register read and write happens on the single host clock.
// RULE3: The bank answers only at internal addresses starting at base 0000_A400h.
// RULE4: Status sits at offset 00h, clock enable at 08h and standby-supply control at 18h.
// RULE5: Status bit 7, the battery-reset flag, is one after a battery power-on reset.
// RULE6: Writing one to the battery-reset flag clears it and writing zero leaves it.
// RULE7: Status bit 5, the watchdog flag, becomes one after a watchdog reset and is zero after power-on.
// RULE8: The watchdog flag clears only on a written one; a written zero does nothing.
// RULE9: Status bit 0 is read-only and shows whether a slow clock is seen on the crystal pins.
// RULE10: The latched event flags are kept while the main standby supply is off.
// RULE11: An interrupt output from the status register signals the battery-reset and watchdog events.
// RULE12: Boot firmware writes 0x5 to the watchdog fire tally before forcing a reset with the watchdog.
// RULE13: Firmware clears both watchdog status bits before it enables the watchdog.
// RULE14: The interrupt stays high while either flag is one and drops once both are clear.
// RULE15: Status bits 6 and 4 to 1 read as zero and ignore writes.
`timescale 1ns/1ns
module battery_backed_status_bank
    import status_bank_pkg::*;
(
    input  wire logic     i_core_clk,
    input  wire logic     i_rst_n,
    input  wire reg_req_t i_req,
    output reg_rsp_t      o_rsp,
    input  wire logic     i_watchdog_reset,
    input  wire logic     i_slow_clock_detect,
    input  wire logic     i_main_standby_ok,
    output logic [31:0]   o_clock_enable,
    output logic [31:0]   o_alt_standby_control,
    output logic          o_power_fail_irq
);

    function automatic logic ofs_hit(input logic [31:0] addr, input logic [4:0] ofs);
        ofs_hit = (addr[31:BANK_SPAN_BITS] == BANK_BASE[31:BANK_SPAN_BITS])
                  && (addr[BANK_SPAN_BITS-1:0] == ofs);
    endfunction

    logic        slow_clk_sync;
    logic        standby_ok_sync;
    logic        batt_flag;
    logic        wdt_flag;
    logic [31:0] clock_enable_r;
    logic [31:0] clock_enable_nxt;
    logic [31:0] alt_standby_r;
    logic [31:0] alt_standby_nxt;
    reg_rsp_t    rsp_r;
    reg_rsp_t    rsp_nxt;
    logic        irq_r;

    // Crystal detect and supply-good come from other domains
    level_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_slow_clock_detect, i_main_standby_ok}),
        .o_sync     ({slow_clk_sync, standby_ok_sync})
    );

    // Address decode
    wire hit_status   = ofs_hit(i_req.addr, OFS_PF_STATUS); // RULE4
    wire hit_test_a   = ofs_hit(i_req.addr, OFS_TEST_A);
    wire hit_clk_en   = ofs_hit(i_req.addr, OFS_CLOCK_ENABLE); // RULE4
    wire hit_test_b   = ofs_hit(i_req.addr, OFS_TEST_B);
    wire hit_test_c   = ofs_hit(i_req.addr, OFS_TEST_C);
    wire hit_alt_sb   = ofs_hit(i_req.addr, OFS_ALT_STANDBY); // RULE4
    wire hit_test_d   = ofs_hit(i_req.addr, OFS_TEST_D);
    wire in_bank      = (i_req.addr[31:BANK_SPAN_BITS] == BANK_BASE[31:BANK_SPAN_BITS]); // RULE3
    wire hit_test     = hit_test_a | hit_test_b | hit_test_c | hit_test_d;

    // Accesses only count while the controller side is powered
    wire req_live     = i_req.valid & standby_ok_sync & in_bank; // RULE10
    wire wr_live      = req_live & i_req.write; // RULE2
    wire rd_live      = req_live & ~i_req.write;

    wire wr_status    = wr_live & hit_status;
    wire wr_clk_en    = wr_live & hit_clk_en;
    wire wr_alt_sb    = wr_live & hit_alt_sb;

    wire batt_clear   = wr_status & i_req.wdata[BIT_BATT_RST]; // RULE6
    wire wdt_clear    = wr_status & i_req.wdata[BIT_WATCHDOG]; // RULE8

    // Battery-reset flag: reset value one, only cleared by a written one
    w1c_flag #(
        .RESET_VAL (RST_BATT_RST)
    ) u_batt_flag (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (1'b0),
        .i_clear    (batt_clear),
        .o_flag     (batt_flag)
    ); // RULE5

    // Watchdog flag: set by a watchdog-forced reset event
    w1c_flag #(
        .RESET_VAL (RST_WATCHDOG)
    ) u_wdt_flag (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (i_watchdog_reset),
        .i_clear    (wdt_clear),
        .o_flag     (wdt_flag)
    ); // RULE7

    // Status read image; reserved bits are zero
    wire [7:0] status_image = {batt_flag, 1'b0, wdt_flag, 4'h0, slow_clk_sync}; // RULE9 RULE15

    assign clock_enable_nxt = wr_clk_en ? (i_req.wdata & MASK_CLOCK_ENABLE) : clock_enable_r;
    assign alt_standby_nxt  = wr_alt_sb ? (i_req.wdata & MASK_ALT_STANDBY) : alt_standby_r;

    // Read data select; test and unmapped words read zero
    wire [31:0] rd_word = hit_status ? {24'h00_0000, status_image} :
                          hit_clk_en ? clock_enable_r :
                          hit_alt_sb ? alt_standby_r :
                          hit_test   ? 32'h0000_0000 :
                                       32'h0000_0000;

    always_comb begin
        rsp_nxt.valid = req_live;
        rsp_nxt.rdata = rd_live ? rd_word : 32'h0000_0000;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            clock_enable_r <= RST_CLOCK_ENABLE; // RULE1
            alt_standby_r  <= RST_ALT_STANDBY; // RULE1
            rsp_r          <= '0;
            irq_r          <= 1'b0;
        end else begin
            clock_enable_r <= clock_enable_nxt;
            alt_standby_r  <= alt_standby_nxt;
            rsp_r          <= rsp_nxt;
            irq_r          <= batt_flag | wdt_flag; // RULE11 RULE14
        end
    end

    assign o_rsp                 = rsp_r;
    assign o_clock_enable        = clock_enable_r;
    assign o_alt_standby_control = alt_standby_r;
    assign o_power_fail_irq      = irq_r;

endmodule

// ---- hdl/level_sync.sv ----
`timescale 1ns/1ns
module level_sync
    import status_bank_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= i_async;
            stage2_r <= stage1_r;
        end
    end

    assign o_sync = stage2_r;
endmodule

// ---- hdl/status_bank_pkg.sv ----
package status_bank_pkg;

    localparam logic [31:0] BANK_BASE          = 32'h0000_A400;
    localparam int          BANK_SPAN_BITS     = 5;

    localparam logic [4:0]  OFS_PF_STATUS      = 5'h00;
    localparam logic [4:0]  OFS_TEST_A         = 5'h04;
    localparam logic [4:0]  OFS_CLOCK_ENABLE   = 5'h08;
    localparam logic [4:0]  OFS_TEST_B         = 5'h10;
    localparam logic [4:0]  OFS_TEST_C         = 5'h14;
    localparam logic [4:0]  OFS_ALT_STANDBY    = 5'h18;
    localparam logic [4:0]  OFS_TEST_D         = 5'h1C;

    localparam int          BIT_BATT_RST       = 7;
    localparam int          BIT_WATCHDOG       = 5;
    localparam int          BIT_SLOW_CLK       = 0;

    localparam logic        RST_BATT_RST       = 1'h1;
    localparam logic        RST_WATCHDOG       = 1'h0;
    localparam logic [31:0] RST_CLOCK_ENABLE   = 32'h0000_0000;
    localparam logic [31:0] RST_ALT_STANDBY    = 32'h0000_0000;
    localparam logic [31:0] MASK_CLOCK_ENABLE  = 32'h0000_003F;
    localparam logic [31:0] MASK_ALT_STANDBY   = 32'hFFFF_FFFF;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } reg_rsp_t;

endpackage

// ---- hdl/w1c_flag.sv ----
`timescale 1ns/1ns
module w1c_flag
    import status_bank_pkg::*;
#(
    parameter logic RESET_VAL = 1'h0
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);
    logic flag_r;
    logic flag_nxt;

    // Set wins over a clear in the same cycle
    assign flag_nxt = i_set | (flag_r & ~i_clear);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            flag_r <= RESET_VAL;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign o_flag = flag_r;
endmodule
